// ### cmt_defs.svh
// Constants of the capture/match timer: offsets, fields, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CMT_DEFS_SVH
`define CMT_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define CMT_NCH          4
`define CMT_NSYNC        5
`define CMT_TCLK_BIT     4
`define CMT_W            32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CMT_OFS_CTRL     8'h00
`define CMT_OFS_TC       8'h04
`define CMT_OFS_PR       8'h08
`define CMT_OFS_PC       8'h0C
`define CMT_OFS_MCR      8'h10
`define CMT_OFS_CCR      8'h14
`define CMT_OFS_EMR      8'h18
`define CMT_OFS_IR       8'h1C
`define CMT_RGN_MR       4'h2
`define CMT_RGN_CR       4'h3
`define CMT_ADDR_W       8
`define CMT_RGN_HI       7
`define CMT_RGN_LO       4
`define CMT_IDX_HI       3
`define CMT_IDX_LO       2

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CMT_CTRL_EN      0
`define CMT_CTRL_RST     1
`define CMT_MCR_INT      0
`define CMT_MCR_RST      1
`define CMT_MCR_STOP     2
`define CMT_CCR_RISE     0
`define CMT_CCR_FALL     1
`define CMT_CCR_INT      2
`define CMT_FLD_W        3
`define CMT_EMR_ACT_LSB  4
`define CMT_IR_CAP_LSB   4
`define CMT_HTRANS_ACT   1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMT_RST_WORD     32'h0000_0000
`define CMT_RST_CTRL     2'h0
`define CMT_RST_FLD      12'h000
`define CMT_RST_IR       8'h00
`define CMT_RST_SYNC     5'h00
`define CMT_RST_EMS      4'h0
`define CMT_RST_ADDR     8'h00
`define CMT_ONE_WORD     32'h0000_0001

`endif

// ### cmt_pkg.sv
// Types shared by the capture/match timer modules.
// Assumes cmt_defs.svh is reachable by bare name.
`include "cmt_defs.svh"

package cmt_pkg;

  typedef logic [`CMT_W-1:0] cmt_word_t;

  // External match output action per channel
  typedef enum logic [1:0] {
    CMT_EM_NONE   = 2'h0,
    CMT_EM_LOW    = 2'h1,
    CMT_EM_HIGH   = 2'h2,
    CMT_EM_TOGGLE = 2'h3
  } cmt_match_act_e;

endpackage

// ### cmt_edge_if.sv
// Interface between the timer core and its pin synchroniser.
// Assumes one clock; raw bits are asynchronous pins.
`timescale 1ns/1ns
`include "cmt_defs.svh"

interface cmt_edge_if;
  logic [`CMT_NSYNC-1:0] raw;
  logic [`CMT_NSYNC-1:0] rise;
  logic [`CMT_NSYNC-1:0] fall;

  modport core (output raw, input rise, input fall);
  modport det  (input raw, output rise, output fall);
endinterface

// ### cmt_edge.sv
// Two-flop synchroniser and edge detector for the timer's pin inputs.
// Assumes raw inputs are asynchronous to hclk.
`timescale 1ns/1ns
`include "cmt_defs.svh"

module cmt_edge
  import cmt_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  cmt_edge_if.det   pins
);

  logic [`CMT_NSYNC-1:0] s1_q, s1_d;
  logic [`CMT_NSYNC-1:0] s2_q, s2_d;
  logic [`CMT_NSYNC-1:0] s3_q, s3_d;

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  // First stage feeds only the second; edges come from stages two and three
  always_comb begin
    s1_d = pins.raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= `CMT_RST_SYNC;
      s2_q <= `CMT_RST_SYNC;
      s3_q <= `CMT_RST_SYNC;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign pins.rise = s2_q & ~s3_q;
  assign pins.fall = ~s2_q & s3_q;

endmodule

// ### cmt_timer.sv
// Capture/match timer: 32-bit prescaler, 32-bit counter, four capture
// and four match channels, AHB-Lite register slave.
// Assumes a single-slave AHB-Lite bus on hclk; timer clock and capture
// inputs are asynchronous pins, timer clock well below hclk / 4.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`include "cmt_defs.svh"

module cmt_timer
  import cmt_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 timer_counter_clock,
  input  wire logic [`CMT_NCH-1:0]  capture_input,
  output logic [`CMT_NCH-1:0]       match_output,
  output logic                      irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  cmt_word_t                     tc_q, tc_d;
  cmt_word_t                     pc_q, pc_d;
  cmt_word_t                     pr_q, pr_d;
  logic [1:0]                    ctrl_q, ctrl_d;
  logic [`CMT_NCH*`CMT_FLD_W-1:0] mcr_q, mcr_d;
  logic [`CMT_NCH*`CMT_FLD_W-1:0] ccr_q, ccr_d;
  logic [`CMT_NCH-1:0]           ems_q, ems_d;
  logic [2*`CMT_NCH-1:0]         ema_q, ema_d;
  logic [2*`CMT_NCH-1:0]         ir_q, ir_d;
  logic                          irq_q, irq_d;
  cmt_word_t                     mr_q [`CMT_NCH];
  cmt_word_t                     cr_q [`CMT_NCH];

  logic                          wr_q, wr_d;
  logic [7:0]                    addr_q, addr_d;
  cmt_word_t                     rdata_q, rdata_d;
  logic                          ready_q;
  logic                          resp_q;
  cmt_word_t                     rd_mux;
  logic                          ready_d;
  logic                          resp_d;
  logic [3:0]                    a_rgn;
  logic [1:0]                    a_idx;
  logic [3:0]                    w_rgn;
  logic [1:0]                    w_idx;

  logic                          tick;
  logic                          run;
  logic                          terminal;
  logic [`CMT_NCH-1:0]           match_hit;
  logic [`CMT_NCH-1:0]           cap_hit;
  logic [`CMT_NCH-1:0]           rst_hit;
  logic [`CMT_NCH-1:0]           stop_hit;
  logic                          sel;
  logic [`CMT_NCH-1:0]           mr_we;

  cmt_edge_if edges ();

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  assign edges.raw = {timer_counter_clock, capture_input};

  cmt_edge u_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pins    (edges)
  );

  // A timer clock above a quarter of hclk loses ticks without notice
  // One tick per timer clock period, taken after the crossing
  assign tick     = edges.rise[`CMT_TCLK_BIT];
  assign run      = tick & ctrl_q[`CMT_CTRL_EN] & ~ctrl_q[`CMT_CTRL_RST];
  assign terminal = run & (pc_q == pr_q);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Zero wait states: read data is sampled in the address phase, so a
  // read right behind a write to the same register sees the old value.
  assign sel = hsel & hready & htrans[`CMT_HTRANS_ACT];

  assign a_rgn = haddr[`CMT_RGN_HI:`CMT_RGN_LO];
  assign a_idx = haddr[`CMT_IDX_HI:`CMT_IDX_LO];
  assign w_rgn = addr_q[`CMT_RGN_HI:`CMT_RGN_LO];
  assign w_idx = addr_q[`CMT_IDX_HI:`CMT_IDX_LO];

  always_comb begin
    rd_mux = `CMT_RST_WORD;
    unique case (haddr[`CMT_ADDR_W-1:0])
      `CMT_OFS_CTRL: rd_mux = {30'h0000_0000, ctrl_q};
      `CMT_OFS_TC:   rd_mux = tc_q;
      `CMT_OFS_PR:   rd_mux = pr_q;
      `CMT_OFS_PC:   rd_mux = pc_q;
      `CMT_OFS_MCR:  rd_mux = {20'h0_0000, mcr_q};
      `CMT_OFS_CCR:  rd_mux = {20'h0_0000, ccr_q};
      `CMT_OFS_EMR:  rd_mux = {20'h0_0000, ema_q, ems_q};
      `CMT_OFS_IR:   rd_mux = {24'h00_0000, ir_q};
      default: begin
        if (a_rgn == `CMT_RGN_MR) begin
          rd_mux = mr_q[a_idx];
        end else if (a_rgn == `CMT_RGN_CR) begin
          rd_mux = cr_q[a_idx];
        end
      end
    endcase
  end

  always_comb begin
    wr_d    = sel & hwrite;
    addr_d  = sel ? haddr[`CMT_ADDR_W-1:0] : addr_q;
    rdata_d = (sel & ~hwrite) ? rd_mux : `CMT_RST_WORD;
    // Never stretches or fails a transfer, so masters need no wait logic
    ready_d = 1'b1;
    resp_d  = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q    <= 1'b0;
      addr_q  <= `CMT_RST_ADDR;
      rdata_q <= `CMT_RST_WORD;
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q  <= resp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel match and capture
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CMT_NCH; gi = gi + 1) begin : g_ch
      cmt_word_t mr_d;
      cmt_word_t cr_d;

      assign match_hit[gi] = terminal & (tc_q == mr_q[gi]);
      assign rst_hit[gi]   = match_hit[gi] & mcr_q[gi*`CMT_FLD_W+`CMT_MCR_RST];
      assign stop_hit[gi]  = match_hit[gi] & mcr_q[gi*`CMT_FLD_W+`CMT_MCR_STOP];
      assign cap_hit[gi]   = (edges.rise[gi] & ccr_q[gi*`CMT_FLD_W+`CMT_CCR_RISE])
                           | (edges.fall[gi] & ccr_q[gi*`CMT_FLD_W+`CMT_CCR_FALL]);
      assign mr_we[gi]     = wr_q & (w_rgn == `CMT_RGN_MR)
                           & (w_idx == 2'(gi));

      always_comb begin
        mr_d = mr_we[gi] ? hwdata : mr_q[gi];
        cr_d = cap_hit[gi] ? tc_q : cr_q[gi];
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          mr_q[gi] <= `CMT_RST_WORD;
          cr_q[gi] <= `CMT_RST_WORD;
        end else begin
          mr_q[gi] <= mr_d;
          cr_q[gi] <= cr_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Counters and control
  // ----------------------------------------------------------------------
  // Hardware actions are applied after software writes, so an event in
  // the same cycle as a write wins.
  always_comb begin
    tc_d  = tc_q;
    pc_d  = pc_q;
    pr_d  = pr_q;
    ctrl_d = ctrl_q;
    mcr_d = mcr_q;
    ccr_d = ccr_q;
    ems_d = ems_q;
    ema_d = ema_q;
    ir_d  = ir_q;

    if (wr_q) begin
      unique case (addr_q)
        `CMT_OFS_CTRL: ctrl_d = hwdata[1:0];
        `CMT_OFS_TC: begin
          tc_d = hwdata;
          pc_d = `CMT_RST_WORD;
        end
        `CMT_OFS_PR:   pr_d = hwdata;
        `CMT_OFS_MCR:  mcr_d = hwdata[`CMT_NCH*`CMT_FLD_W-1:0];
        `CMT_OFS_CCR:  ccr_d = hwdata[`CMT_NCH*`CMT_FLD_W-1:0];
        `CMT_OFS_EMR: begin
          ems_d = hwdata[`CMT_NCH-1:0];
          ema_d = hwdata[`CMT_EMR_ACT_LSB +: 2*`CMT_NCH];
        end
        `CMT_OFS_IR:   ir_d = ir_q & ~hwdata[2*`CMT_NCH-1:0];
        default: ;
      endcase
    end

    if (run) begin
      if (|rst_hit) begin
        tc_d = `CMT_RST_WORD;
        pc_d = `CMT_RST_WORD;
      end else if (terminal) begin
        tc_d = tc_q + `CMT_ONE_WORD;
        pc_d = `CMT_RST_WORD;
      end else begin
        pc_d = pc_q + `CMT_ONE_WORD;
      end
    end
    // Stop beats a software enable written in the same cycle
    if (|stop_hit) begin
      ctrl_d[`CMT_CTRL_EN] = 1'b0;
    end
    if (ctrl_q[`CMT_CTRL_RST]) begin
      tc_d = `CMT_RST_WORD;
      pc_d = `CMT_RST_WORD;
    end

    for (int i = 0; i < `CMT_NCH; i++) begin
      if (match_hit[i]) begin
        unique case (cmt_match_act_e'(ema_q[2*i +: 2]))
          CMT_EM_LOW:    ems_d[i] = 1'b0;
          CMT_EM_HIGH:   ems_d[i] = 1'b1;
          CMT_EM_TOGGLE: ems_d[i] = ~ems_q[i];
          CMT_EM_NONE:   ems_d[i] = ems_q[i];
        endcase
        if (mcr_q[i*`CMT_FLD_W+`CMT_MCR_INT]) begin
          ir_d[i] = 1'b1;
        end
      end
      if (cap_hit[i] && ccr_q[i*`CMT_FLD_W+`CMT_CCR_INT]) begin
        ir_d[`CMT_IR_CAP_LSB+i] = 1'b1;
      end
    end

    irq_d = |ir_d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tc_q   <= `CMT_RST_WORD;
      pc_q   <= `CMT_RST_WORD;
      pr_q   <= `CMT_RST_WORD;
      ctrl_q <= `CMT_RST_CTRL;
      mcr_q  <= `CMT_RST_FLD;
      ccr_q  <= `CMT_RST_FLD;
      ems_q  <= `CMT_RST_EMS;
      ema_q  <= `CMT_RST_IR;
      ir_q   <= `CMT_RST_IR;
      irq_q  <= 1'b0;
    end else begin
      tc_q   <= tc_d;
      pc_q   <= pc_d;
      pr_q   <= pr_d;
      ctrl_q <= ctrl_d;
      mcr_q  <= mcr_d;
      ccr_q  <= ccr_d;
      ems_q  <= ems_d;
      ema_q  <= ema_d;
      ir_q   <= ir_d;
      irq_q  <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout    = ready_q;
  assign hresp        = resp_q;
  assign hrdata       = rdata_q;
  assign match_output = ems_q;
  assign irq          = irq_q;

endmodule

// ### cmt_timer_sva.sv
// Checker of the timer's bus answers, match pins and interrupt line.
// Assumes it is bound into cmt_timer; one clock, async active-low reset.
`timescale 1ns/1ns
`include "cmt_defs.svh"

module cmt_timer_sva (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [31:0]         hrdata,
  input wire logic                timer_counter_clock,
  input wire logic [`CMT_NCH-1:0] capture_input,
  input wire logic [`CMT_NCH-1:0] match_output,
  input wire logic                irq
);
  logic [7:0]          tck_q;
  logic [7:0]          chg_q;
  logic [`CMT_NCH-1:0] cap_q;
  logic                wr_q;
  logic                rd_q;
  logic                tck_seen;
  logic                chg_seen;

  // ---------------------------------------------------------------
  // Recent causes
  // ---------------------------------------------------------------
  // Eight cycles cover synchroniser plus edge detector latency
  assign tck_seen = |(tck_q[6:0] & ~tck_q[7:1]);
  assign chg_seen = |chg_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_q <= 8'h00;
      chg_q <= 8'h00;
      cap_q <= 4'h0;
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
    end else begin
      tck_q <= {tck_q[6:0], timer_counter_clock};
      chg_q <= {chg_q[6:0], capture_input != cap_q};
      cap_q <= capture_input;
      wr_q  <= hsel & hready & htrans[1] & hwrite;
      rd_q  <= hsel & hready & htrans[1] & ~hwrite;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_quiet: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_reset_quiet: assert property ($rose(hresetn) |-> match_output == 4'h0 && !irq)
    else $error("pins active after reset");
  a_match_cause: assert property ($changed(match_output) |-> tck_seen || $past(wr_q))
    else $error("match pin moved without tick or write");
  a_irq_cause: assert property ($rose(irq) |-> tck_seen || chg_seen)
    else $error("interrupt without event");
  a_irq_clear: assert property ($fell(irq) |-> $past(wr_q))
    else $error("interrupt dropped without write");
  a_sync_delay: assert property ($changed(capture_input) && !tck_seen |=> !$rose(irq) [*2])
    else $error("capture seen without synchroniser delay");

  c_irq_rise: cover property ($rose(irq));
  c_match_move: cover property ($changed(match_output) && tck_seen);
  c_read_data: cover property (rd_q && hrdata != 32'h0000_0000);
endmodule

bind cmt_timer cmt_timer_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .timer_counter_clock(timer_counter_clock),
  .capture_input(capture_input), .match_output(match_output), .irq(irq));

// ### cmt_pins_model.sv
// Far side of the timer: timer clock source and capture signal drivers.
// Assumes calls from the bench right after a rising hclk edge.
`timescale 1ns/1ns
`include "cmt_defs.svh"

module cmt_pins_model
  import cmt_pkg::*;
(
  input  wire logic                hclk,
  output logic                     timer_counter_clock,
  output logic [`CMT_NCH-1:0]      capture_input
);
  initial begin
    timer_counter_clock = 1'b0;
    capture_input = 4'h0;
  end

  // One timer period; clock stands low between calls
  task automatic pulse(input int half);
    timer_counter_clock <= 1'b1;
    repeat (half) @(posedge hclk);
    timer_counter_clock <= 1'b0;
    repeat (half) @(posedge hclk);
  endtask

  task automatic set_caps(input logic [`CMT_NCH-1:0] v);
    capture_input <= v;
    @(posedge hclk);
  endtask
endmodule

// ### test_capture_match_timer.sv
// Self-checking bench: AHB-Lite master, pin partner, integer model.
// Assumes cmt_timer, cmt_pins_model and the bound checker are compiled.
`timescale 1ns/1ns
`include "cmt_defs.svh"

module test_capture_match_timer import cmt_pkg::*;;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, tclk;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  caps, mout, v;
  int          seed, n_errors, total_checks, cycles, tc, pc, pr, mcr, emr, ir;
  int          mr[4], cr[4];
  bit          en;

  assign hready = hreadyout;
  cmt_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer_counter_clock(tclk),
    .capture_input(caps), .match_output(mout), .irq(irq));
  cmt_pins_model i_pins (.hclk(hclk), .timer_counter_clock(tclk), .capture_input(caps));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Run is about 800 cycles; hang limit well above
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Bus, compare and model tasks
  // ---------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input cmt_word_t d,
                     output cmt_word_t q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input cmt_word_t d);
    cmt_word_t q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic chk_reg(input logic [7:0] a, input cmt_word_t exp);
    cmt_word_t q;
    ahb(1'b0, a, 32'h0000_0000, q);
    total_checks++;
    if (q !== exp) begin
      n_errors++;
      $display("unexpected reg %h: expected %h seen %h", a, exp, q);
    end
  endtask

  task automatic chk_pin(input logic [4:0] exp);
    // Let the edge that launched the pins pass before looking
    @(posedge hclk);
    total_checks++;
    if ({irq, mout} !== exp) begin
      n_errors++;
      $display("unexpected irq/match pins: expected %h seen %h", exp, {irq, mout});
    end
  endtask

  task automatic step();
    bit rst;
    if (!en) return;
    if (pc != pr) begin
      pc++;
      return;
    end
    pc = 0;
    rst = 0;
    for (int n = 0; n < 4; n++) if (tc == mr[n]) begin
      ir |= ((mcr >> 3*n) & 1) << n;
      rst |= (mcr >> (3*n + 1)) & 1;
      if ((mcr >> (3*n + 2)) & 1) en = 0;
      case ((emr >> (4 + 2*n)) & 3)
        1: emr &= ~(1 << n);
        2: emr |= 1 << n;
        3: emr ^= 1 << n;
        default: ;
      endcase
    end
    tc = rst ? 0 : tc + 1;
  endtask

  task automatic run(input int n);
    repeat (n) begin
      i_pins.pulse(3 + ($random(seed) & 3));
      step();
    end
    repeat (4) @(posedge hclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 32'hF490985E;
    {tc, pc, ir, en} = '0;
    cr = '{default: 0};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 'h40; a += 4) chk_reg(a[7:0], 32'h0000_0000);
    chk_pin(5'h00);
    // Matches below MR0 so every channel fires before the wrap
    pr = $random(seed) & 3;
    mr[0] = 4 + ($random(seed) & 3);
    for (int n = 1; n < 4; n++) mr[n] = $random(seed) & 3;
    mcr = 'h24B;
    emr = ('hE4 << 4) | ($random(seed) & 'hF);
    wr(`CMT_OFS_PR, pr);
    wr(`CMT_OFS_MCR, mcr);
    wr(`CMT_OFS_EMR, emr);
    for (int n = 0; n < 4; n++) wr({`CMT_RGN_MR, 2'(n), 2'h0}, mr[n]);
    for (int n = 0; n < 4; n++) chk_reg({`CMT_RGN_MR, 2'(n), 2'h0}, mr[n]);
    chk_reg(`CMT_OFS_EMR, emr);
    wr(`CMT_OFS_CTRL, 1);
    en = 1;
    run(40);
    chk_reg(`CMT_OFS_TC, tc);
    chk_reg(`CMT_OFS_PC, pc);
    chk_reg(`CMT_OFS_IR, ir);
    chk_pin({ir != 0, emr[3:0]});
    wr(`CMT_OFS_IR, 'hFF);
    ir = 0;
    chk_pin({1'b0, emr[3:0]});
    mcr = 'h20;
    wr(`CMT_OFS_MCR, mcr);
    wr(`CMT_OFS_CTRL, 2);
    wr(`CMT_OFS_CTRL, 1);
    tc = 0;
    pc = 0;
    run(30);
    chk_reg(`CMT_OFS_CTRL, en);
    chk_reg(`CMT_OFS_TC, tc);
    // All channels capture rises; channel three also captures falls
    wr(`CMT_OFS_CCR, 12'hF6D);
    v = (4'($random(seed)) & 4'h6) | 4'h9;
    i_pins.set_caps(v);
    repeat (6) @(posedge hclk);
    for (int n = 0; n < 4; n++) if (v[n]) cr[n] = tc;
    ir |= v << 4;
    for (int n = 0; n < 4; n++) chk_reg({`CMT_RGN_CR, 2'(n), 2'h0}, cr[n]);
    chk_pin({1'b1, emr[3:0]});
    chk_reg(`CMT_OFS_IR, ir);
    // New count so the falling capture stores a fresh value
    wr(`CMT_OFS_IR, 8'hFF);
    tc = $random(seed);
    wr(`CMT_OFS_TC, tc);
    i_pins.set_caps(4'h0);
    repeat (6) @(posedge hclk);
    cr[3] = tc;
    ir = 32'h0000_0080;
    chk_reg({`CMT_RGN_CR, 2'h3, 2'h0}, cr[3]);
    chk_reg(`CMT_OFS_IR, ir);
    print_verdict();
  end
endmodule
